// File: hw/pbs_sync_ctrl.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Three hardware trigger inputs, each live only while its enable bit is one.
// - Inputs are sampled on the clock; a rising edge on an enabled input starts sync.
// - Keep mode zero: enable clears on write of zero or own event only.
// - Event plus simultaneous write setting the same enable: sync starts, bit stays set.
// - Keep mode one: enable clears only on a software write of zero.
// - Writing one to software request makes an event; clears on zero write or completion.
// - New request written as the previous one completes starts again and stays one.
// - Legacy: request clears at event if hw-only zero and reload one, else loading point.
// - Enhanced: request clears at loading point if restart zero, at event if one.
// - Up counting wrap, or up-down direction reversal, is a boundary cycle.
// - Boundaries load only with min or max bits set; up-down selects bottom and top.
// - Period limit sync copies buffer to active, needs extended enable, either scheme.
// - Legacy, hw-only and reload zero: period loads at next loading point after event.
// - Legacy, hw-only zero, reload one: period loads at next enabled trigger event.
// - Legacy, hw-only one: period loads at loading point after software event.
// - Start value sync needs extended, enhanced and start sync bits; same mechanism.
// - Pair compare sync needs extended and pair sync bits; same mechanism as period.
// - Blanking loads every clock when its sync select is zero, else by the scheme.
// - Legacy blanking, hw-only zero: loads on next trigger; request clears at loading point if reload zero, at event if one.
// - Legacy blanking, hw-only one: loads only on next enabled hardware trigger.
// - Swap loads every clock with select zero; enhanced sync gated by its enables otherwise.
module pbs_sync_ctrl #(
	parameter int NUM_TRIG = pbs_pkg::NUM_TRIG,
	parameter int VAL_W = pbs_pkg::VAL_W,
	parameter int NUM_PAIRS = pbs_pkg::NUM_PAIRS,
	parameter int MASK_W = pbs_pkg::MASK_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire pbs_pkg::pbs_req_t req,
	output logic [31:0] rdata,
	// Hardware triggers, synchronous to clk
	input wire logic [NUM_TRIG-1:0] hw_trigger,
	// Counter status from the timer core
	input wire pbs_pkg::pbs_cnt_t cnt,
	// Active values
	output logic [VAL_W-1:0] period_limit,
	output logic [VAL_W-1:0] count_start_value,
	output logic [2*NUM_PAIRS*VAL_W-1:0] channel_compare_value,
	output logic [MASK_W-1:0] output_blanking,
	output logic [NUM_PAIRS-1:0] swap_control
);

	// Parameters the fixed register map can serve
	initial
	begin
		if (NUM_TRIG != 3 || VAL_W < 1 || VAL_W > 32 || MASK_W > 32 || NUM_PAIRS < 1
			|| NUM_PAIRS > 4)
			$error("pbs_sync_ctrl: unsupported parameters");
	end

	logic [pbs_pkg::CTRL_W-1:0] ctrl_q;
	logic [NUM_TRIG-1:0] trig_en_q, trig_en_d;
	logic [NUM_TRIG-1:0] trig_prev_q;
	logic sw_req_q, sw_req_d;
	logic sw_pend_q, sw_pend_d;
	logic hw_pend_q, hw_pend_d;
	logic [VAL_W-1:0] period_buf_q, start_buf_q;
	logic [MASK_W-1:0] blank_buf_q;
	logic [NUM_PAIRS-1:0] swap_buf_q;
	logic [VAL_W-1:0] cmp_buf_q [2*NUM_PAIRS];
	logic [VAL_W-1:0] cmp_act_q [2*NUM_PAIRS];
	logic [31:0] rdata_q;

	// Named control bits
	wire ext_en = ctrl_q[pbs_pkg::B_EXT_EN];
	wire enh = ctrl_q[pbs_pkg::B_ENH];
	wire keep = ctrl_q[pbs_pkg::B_KEEP];
	wire hw_only = ctrl_q[pbs_pkg::B_HW_ONLY];
	wire reload = ctrl_q[pbs_pkg::B_RELOAD];
	wire sw_rst = ctrl_q[pbs_pkg::B_SW_RST];
	wire hw_rst = ctrl_q[pbs_pkg::B_HW_RST];
	wire sw_wrbuf = ctrl_q[pbs_pkg::B_SW_WRBUF];
	wire hw_wrbuf = ctrl_q[pbs_pkg::B_HW_WRBUF];
	wire load_min = ctrl_q[pbs_pkg::B_LOAD_MIN];
	wire load_max = ctrl_q[pbs_pkg::B_LOAD_MAX];
	wire start_sync = ctrl_q[pbs_pkg::B_START_SYNC];
	wire blank_sync = ctrl_q[pbs_pkg::B_BLANK_SYNC];
	wire blank_sw = ctrl_q[pbs_pkg::B_BLANK_SW];
	wire blank_hw = ctrl_q[pbs_pkg::B_BLANK_HW];
	wire swap_sync = ctrl_q[pbs_pkg::B_SWAP_SYNC];
	wire swap_sw = ctrl_q[pbs_pkg::B_SWAP_SW];
	wire swap_hw = ctrl_q[pbs_pkg::B_SWAP_HW];
	wire [NUM_PAIRS-1:0] pair_sync = ctrl_q[pbs_pkg::B_PAIR_SYNC +: NUM_PAIRS];

	// Address decode
	function automatic logic hit_wr(input pbs_pkg::pbs_req_t r, input logic [3:0] a);
		return r.wr && (r.addr == a);
	endfunction

	wire wr_ctrl = hit_wr(req, pbs_pkg::ADDR_CTRL);
	wire wr_trig = hit_wr(req, pbs_pkg::ADDR_TRIG);

	// Trigger edge detect; inputs are already on clk so one stage suffices
	wire [NUM_TRIG-1:0] trig_rise = hw_trigger & ~trig_prev_q;
	wire [NUM_TRIG-1:0] trig_evt = trig_rise & trig_en_q;
	wire hw_evt = |trig_evt;
	wire sw_evt = wr_trig && req.wdata[pbs_pkg::B_SW_REQ];

	// Boundary cycles and selected loading points
	wire boundary = cnt.up_down ? (cnt.turn_bottom | cnt.turn_top) : cnt.wrap;
	wire load_pt = boundary && (cnt.up_down
		? ((cnt.turn_bottom & load_min) | (cnt.turn_top & load_max))
		: (load_min | load_max));

	// Legacy: which triggers count, and whether the load is immediate
	wire leg_evt = hw_only ? sw_evt : (sw_evt | hw_evt);
	wire leg_now = !hw_only && reload;
	// Enhanced: trigger gated by write-buffer enables
	wire enh_sw = sw_evt && sw_wrbuf;
	wire enh_hw = hw_evt && hw_wrbuf;

	// Pending waits for a loading point
	always_comb
	begin
		sw_pend_d = sw_pend_q;
		hw_pend_d = hw_pend_q;
		if (load_pt)
		begin
			sw_pend_d = 1'b0;
			hw_pend_d = 1'b0;
		end
		if (enh ? (enh_sw && !sw_rst) : (leg_evt && sw_evt && !leg_now))
			sw_pend_d = 1'b1;
		if (enh ? (enh_hw && !hw_rst) : (leg_evt && hw_evt && !leg_now))
			hw_pend_d = 1'b1;
	end

	// Load strobe for the period, start and compare values
	wire load_now = enh ? ((enh_sw && sw_rst) || (enh_hw && hw_rst))
		: (leg_now && leg_evt);
	wire load_late = (sw_pend_q || hw_pend_q) && load_pt;
	wire val_load = load_now || load_late;
	wire period_load = ext_en && val_load;
	wire start_load = ext_en && enh && start_sync && val_load;
	wire [NUM_PAIRS-1:0] pair_load = {NUM_PAIRS{ext_en && val_load}} & pair_sync;

	// Blanking: every clock, or enhanced / legacy trigger
	wire blank_enh = (sw_evt && blank_sw) || (hw_evt && blank_hw);
	wire blank_leg = hw_only ? hw_evt : (sw_evt || hw_evt);
	wire blank_load = !blank_sync || (enh ? blank_enh : blank_leg);
	// Swap: every clock, or enhanced trigger only
	wire swap_load = !swap_sync
		|| (enh && ((sw_evt && swap_sw) || (hw_evt && swap_hw)));

	// Software request clear point
	wire sw_clr_at_evt = enh ? sw_rst : (!hw_only && reload);
	wire sw_done = sw_req_q && (sw_clr_at_evt || load_pt);
	always_comb
	begin
		sw_req_d = sw_req_q;
		if (sw_done)
			sw_req_d = 1'b0;
		if (wr_trig)
			sw_req_d = req.wdata[pbs_pkg::B_SW_REQ];
		if (sw_evt && sw_clr_at_evt)
			sw_req_d = 1'b0;
	end

	// Enable bits: write wins over an event clear
	always_comb
	begin
		trig_en_d = trig_en_q;
		if (!keep)
			trig_en_d = trig_en_q & ~trig_evt;
		if (wr_trig)
			trig_en_d = req.wdata[NUM_TRIG-1:0];
	end

	// Control and trigger state
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_q <= pbs_pkg::CTRL_RST[pbs_pkg::CTRL_W-1:0];
			trig_en_q <= '0;
			trig_prev_q <= '0;
			sw_req_q <= 1'b0;
			sw_pend_q <= 1'b0;
			hw_pend_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= req.wdata[pbs_pkg::CTRL_W-1:0];
			trig_en_q <= trig_en_d;
			trig_prev_q <= hw_trigger;
			sw_req_q <= sw_req_d;
			sw_pend_q <= sw_pend_d;
			hw_pend_q <= hw_pend_d;
		end
	end

	// Buffers written by software
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			period_buf_q <= '0;
			start_buf_q <= '0;
			blank_buf_q <= '0;
			swap_buf_q <= '0;
		end
		else
		begin
			if (hit_wr(req, pbs_pkg::ADDR_PERIOD))
				period_buf_q <= req.wdata[VAL_W-1:0];
			if (hit_wr(req, pbs_pkg::ADDR_START))
				start_buf_q <= req.wdata[VAL_W-1:0];
			if (hit_wr(req, pbs_pkg::ADDR_BLANK))
				blank_buf_q <= req.wdata[MASK_W-1:0];
			if (hit_wr(req, pbs_pkg::ADDR_SWAP))
				swap_buf_q <= req.wdata[NUM_PAIRS-1:0];
		end
	end

	// Active copies
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			period_limit <= '0;
			count_start_value <= '0;
			output_blanking <= '0;
			swap_control <= '0;
		end
		else
		begin
			if (period_load)
				period_limit <= period_buf_q;
			if (start_load)
				count_start_value <= start_buf_q;
			if (blank_load)
				output_blanking <= blank_buf_q;
			if (swap_load)
				swap_control <= swap_buf_q;
		end
	end

	// Compare channels, two per pair
	for (genvar c = 0; c < 2 * NUM_PAIRS; c++)
	begin : g_cmp
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				cmp_buf_q[c] <= '0;
				cmp_act_q[c] <= '0;
			end
			else
			begin
				if (hit_wr(req, pbs_pkg::ADDR_CMP0 + 4'(c)))
					cmp_buf_q[c] <= req.wdata[VAL_W-1:0];
				if (pair_load[c/2])
					cmp_act_q[c] <= cmp_buf_q[c];
			end
		end
		assign channel_compare_value[c*VAL_W +: VAL_W] = cmp_act_q[c];
	end

	// Read mux; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		if (req.addr == pbs_pkg::ADDR_CTRL)
			rd_mux[pbs_pkg::CTRL_W-1:0] = ctrl_q;
		else if (req.addr == pbs_pkg::ADDR_TRIG)
			rd_mux[pbs_pkg::B_SW_REQ:0] = {sw_req_q, trig_en_q};
		else if (req.addr == pbs_pkg::ADDR_PERIOD)
			rd_mux[VAL_W-1:0] = period_limit;
		else if (req.addr == pbs_pkg::ADDR_START)
			rd_mux[VAL_W-1:0] = count_start_value;
		else if (req.addr == pbs_pkg::ADDR_BLANK)
			rd_mux[MASK_W-1:0] = output_blanking;
		else if (req.addr == pbs_pkg::ADDR_SWAP)
			rd_mux[NUM_PAIRS-1:0] = swap_control;
		else if (req.addr == pbs_pkg::ADDR_STATUS)
			rd_mux[1:0] = {hw_pend_q, sw_pend_q};
		else if (req.addr >= pbs_pkg::ADDR_CMP0)
			rd_mux[VAL_W-1:0] = cmp_act_q[3'(req.addr - pbs_pkg::ADDR_CMP0)];
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata_q <= '0;
		else
			rdata_q <= req.rd ? rd_mux : '0;
	end
	assign rdata = rdata_q;

	// Checks
	a_trig_clear_evt: assert property (@(posedge clk) disable iff (srst)
		trig_evt[0] && !keep && !wr_trig |=> !trig_en_q[0])
		else $error("enable not cleared by own event");
	a_trig_keep_hold: assert property (@(posedge clk) disable iff (srst)
		keep && !wr_trig && trig_en_q[1] |=> trig_en_q[1])
		else $error("enable lost in keep mode");
	a_trig_write_wins: assert property (@(posedge clk) disable iff (srst)
		trig_evt[2] && wr_trig && req.wdata[2] |=> trig_en_q[2] && $past(hw_evt))
		else $error("write setting enable lost");
	a_sw_req_restart: assert property (@(posedge clk) disable iff (srst)
		sw_evt && !sw_clr_at_evt |=> sw_req_q)
		else $error("software request lost");
	a_sw_clr_evt: assert property (@(posedge clk) disable iff (srst)
		enh && sw_rst && sw_evt |=> !sw_req_q)
		else $error("request not cleared at event");
	a_period_loadpt: assert property (@(posedge clk) disable iff (srst)
		!enh && !hw_only && !reload && ext_en && sw_evt && !load_pt
		##1 (!wr_ctrl && !srst)[*1] ##0 load_pt |=> period_limit == $past(period_buf_q))
		else $error("period not loaded at loading point");
	a_period_now: assert property (@(posedge clk) disable iff (srst)
		!enh && !hw_only && reload && ext_en && hw_evt |=> period_limit == $past(period_buf_q))
		else $error("period not loaded on event");
	a_blank_free: assert property (@(posedge clk) disable iff (srst)
		!blank_sync |=> output_blanking == $past(blank_buf_q))
		else $error("blanking not following buffer");
	a_swap_hold: assert property (@(posedge clk) disable iff (srst)
		swap_sync && !enh |=> swap_control == $past(swap_control))
		else $error("swap changed without sync");
	a_no_load_pt: assert property (@(posedge clk) disable iff (srst)
		!load_min && !load_max |-> !load_pt)
		else $error("loading point with none selected");

endmodule
`default_nettype wire

// File: hw/pbs_pkg.sv
package pbs_pkg;

	// Widths and counts that more than one place needs
	localparam int NUM_TRIG = 3;
	localparam int VAL_W = 16;
	localparam int NUM_PAIRS = 4;
	localparam int MASK_W = 8;

	// Register port map (word addresses)
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TRIG = 4'h1;
	localparam logic [3:0] ADDR_PERIOD = 4'h2;
	localparam logic [3:0] ADDR_START = 4'h3;
	localparam logic [3:0] ADDR_BLANK = 4'h4;
	localparam logic [3:0] ADDR_SWAP = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_CMP0 = 4'h8;

	// Control register field positions
	localparam int B_EXT_EN = 0;
	localparam int B_ENH = 1;
	localparam int B_KEEP = 2;
	localparam int B_HW_ONLY = 3;
	localparam int B_RELOAD = 4;
	localparam int B_SW_RST = 5;
	localparam int B_HW_RST = 6;
	localparam int B_SW_WRBUF = 7;
	localparam int B_HW_WRBUF = 8;
	localparam int B_LOAD_MIN = 9;
	localparam int B_LOAD_MAX = 10;
	localparam int B_START_SYNC = 11;
	localparam int B_BLANK_SYNC = 12;
	localparam int B_BLANK_SW = 13;
	localparam int B_BLANK_HW = 14;
	localparam int B_SWAP_SYNC = 15;
	localparam int B_SWAP_SW = 16;
	localparam int B_SWAP_HW = 17;
	localparam int B_PAIR_SYNC = 24;
	localparam int CTRL_W = 28;

	// Trigger register fields
	localparam int B_SW_REQ = 3;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pbs_req_t;

	// Counter status from the timer core
	typedef struct packed {
		logic up_down;
		logic wrap;
		logic turn_bottom;
		logic turn_top;
	} pbs_cnt_t;

endpackage

// File: test/pbs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_far_model (
	// Clock
	input wire logic clk,
	// Toward the block
	output logic [2:0] hw_trigger,
	output pbs_pkg::pbs_cnt_t cnt
);

	// Idle sources at time zero
	initial
	begin
		hw_trigger = 3'h0;
		cnt = '0;
	end

	// Counting mode, held between boundaries
	task automatic set_mode(input logic up_down);
		@(posedge clk);
		cnt.up_down <= up_down;
	endtask

	// One-cycle boundary pulse; a wrap only exists in up counting, turns only in up-down
	task automatic boundary(input logic top);
		@(posedge clk);
		if (!cnt.up_down)
			cnt.wrap <= 1'b1;
		else if (top)
			cnt.turn_top <= 1'b1;
		else
			cnt.turn_bottom <= 1'b1;
		@(posedge clk);
		cnt.wrap <= 1'b0;
		cnt.turn_top <= 1'b0;
		cnt.turn_bottom <= 1'b0;
	endtask

	// Trigger source holds its level a few cycles so the edge is never missed
	task automatic fire(input int n);
		@(posedge clk);
		hw_trigger[n] <= 1'b1;
		repeat (3) @(posedge clk);
		hw_trigger[n] <= 1'b0;
	endtask

endmodule
`default_nettype wire

// File: test/pbs_sync_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_sync_ctrl_tb;
	localparam logic [31:0] M_EXT = 32'h0000_0001 << pbs_pkg::B_EXT_EN;
	localparam logic [31:0] M_ENH = 32'h0000_0001 << pbs_pkg::B_ENH;
	localparam logic [31:0] M_KEEP = 32'h0000_0001 << pbs_pkg::B_KEEP;
	localparam logic [31:0] M_RLD = 32'h0000_0001 << pbs_pkg::B_RELOAD;
	localparam logic [31:0] M_HWR = 32'h0000_0001 << pbs_pkg::B_HW_RST;
	localparam logic [31:0] M_SWB = 32'h0000_0001 << pbs_pkg::B_SW_WRBUF;
	localparam logic [31:0] M_HWB = 32'h0000_0001 << pbs_pkg::B_HW_WRBUF;
	localparam logic [31:0] M_MIN = 32'h0000_0001 << pbs_pkg::B_LOAD_MIN;
	localparam logic [31:0] M_MAX = 32'h0000_0001 << pbs_pkg::B_LOAD_MAX;
	localparam logic [31:0] M_STS = 32'h0000_0001 << pbs_pkg::B_START_SYNC;
	localparam logic [31:0] M_PR0 = 32'h0000_0001 << pbs_pkg::B_PAIR_SYNC;
	localparam logic [31:0] M_HWO = 32'h0000_0001 << pbs_pkg::B_HW_ONLY;
	localparam logic [31:0] M_BSY = 32'h0000_0001 << pbs_pkg::B_BLANK_SYNC;
	localparam logic [31:0] M_SWS = 32'h0000_0001 << pbs_pkg::B_SWAP_SYNC;
	localparam logic [31:0] M_SSW = 32'h0000_0001 << pbs_pkg::B_SWAP_SW;
	logic clk = 1'b0;
	logic srst = 1'b1;
	pbs_pkg::pbs_req_t req = '0;
	logic [31:0] rdata;
	logic [2:0] hw_trigger;
	pbs_pkg::pbs_cnt_t cnt;
	logic [15:0] period_limit;
	logic [15:0] count_start_value;
	logic [127:0] channel_compare_value;
	logic [7:0] output_blanking;
	logic [3:0] swap_control;
	int mismatches = 0;
	int compares = 0;
	int seed = 1;
	logic [15:0] v;
	logic [15:0] p;
	logic [31:0] r;

	// Free-running 50 MHz clock
	always #10 clk = ~clk;

	pbs_sync_ctrl pbs_sync_ctrl_i (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
		.hw_trigger(hw_trigger), .cnt(cnt), .period_limit(period_limit),
		.count_start_value(count_start_value), .channel_compare_value(channel_compare_value),
		.output_blanking(output_blanking), .swap_control(swap_control));
	pbs_far_model pbs_far_model_i (.clk(clk), .hw_trigger(hw_trigger), .cnt(cnt));

	// Expected trigger register image from enables and request bit
	function automatic logic [31:0] trig_word(input logic [2:0] en, input logic sw);
		return {28'h0000000, sw, en};
	endfunction

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog sized well beyond the whole sequence
	initial
	begin
		#200000;
		mismatches++;
		results();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		p = 16'h0000;
		rd(pbs_pkg::ADDR_CTRL, r);
		chk(r, pbs_pkg::CTRL_RST);
		chk({16'h0000, period_limit}, 32'h0000_0000);
		$display("test reset done");
		// Unsynchronised blanking and swap follow their buffers each clock
		wr(pbs_pkg::ADDR_CTRL, M_EXT);
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_BLANK, {16'h0000, v});
		wr(pbs_pkg::ADDR_SWAP, {16'h0000, v});
		ticks(2);
		chk({24'h000000, output_blanking}, {24'h000000, v[7:0]});
		chk({28'h0000000, swap_control}, {28'h0000000, v[3:0]});
		$display("test direct done");
		// Legacy deferred load waits for the wrap
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_MIN);
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		ticks(3);
		chk({16'h0000, period_limit}, {16'h0000, p});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h0, 1'b1));
		pbs_far_model_i.boundary(1'b0);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, v});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h0, 1'b0));
		p = v;
		$display("test legacy deferred done");
		// Legacy reload loads period and pair 0 compares at the event, random values
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_RLD | M_MIN | M_PR0);
		repeat (4)
		begin
			v = 16'($random(seed));
			wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
			wr(pbs_pkg::ADDR_CMP0, {16'h0000, ~v});
			wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
			ticks(2);
			chk({16'h0000, period_limit}, {16'h0000, v});
			chk({16'h0000, channel_compare_value[15:0]}, {16'h0000, ~v});
			rd(pbs_pkg::ADDR_TRIG, r);
			chk(r, trig_word(3'h0, 1'b0));
			p = v;
		end
		$display("test legacy reload done");
		// Hardware triggers, keep mode zero: disabled input ignored, own enable clears
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h3, 1'b0));
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		pbs_far_model_i.fire(2);
		ticks(4);
		chk({16'h0000, period_limit}, {16'h0000, p});
		pbs_far_model_i.fire(1);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, v});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h1, 1'b0));
		p = v;
		$display("test hw keep0 done");
		// Keep mode one with the enhanced scheme: hardware restart loads at once, enable stays set
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_ENH | M_KEEP | M_HWB | M_HWR | M_STS);
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h4, 1'b0));
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		wr(pbs_pkg::ADDR_START, {16'h0000, ~v});
		pbs_far_model_i.fire(2);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, v});
		chk({16'h0000, count_start_value}, {16'h0000, ~v});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h4, 1'b0));
		p = v;
		$display("test hw keep1 done");
		// Enhanced software trigger: write-buffer gate, then top-turn loading point only
		pbs_far_model_i.set_mode(1'b1);
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_ENH | M_MAX);
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		pbs_far_model_i.boundary(1'b1);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, p});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h0, 1'b0));
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_ENH | M_MAX | M_SWB);
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		pbs_far_model_i.boundary(1'b0);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, p});
		pbs_far_model_i.boundary(1'b1);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, v});
		p = v;
		$display("test enhanced sw done");
		// Legacy hardware-only: blanking on hw trigger, period on sw event at bottom turn
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_HWO | M_MIN | M_BSY);
		v = 16'($random(seed));
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		wr(pbs_pkg::ADDR_BLANK, {16'h0000, v});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h1, 1'b0));
		pbs_far_model_i.fire(0);
		ticks(2);
		chk({24'h000000, output_blanking}, {24'h000000, v[7:0]});
		chk({16'h0000, period_limit}, {16'h0000, p});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		pbs_far_model_i.boundary(1'b0);
		ticks(2);
		chk({16'h0000, period_limit}, {16'h0000, v});
		rd(pbs_pkg::ADDR_TRIG, r);
		chk(r, trig_word(3'h0, 1'b0));
		p = v;
		// Enhanced swap sync on a software trigger
		wr(pbs_pkg::ADDR_CTRL, M_EXT | M_ENH | M_SWS | M_SSW);
		wr(pbs_pkg::ADDR_SWAP, {16'h0000, ~v});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		ticks(2);
		chk({28'h0000000, swap_control}, {28'h0000000, ~v[3:0]});
		$display("test hw-only and swap done");
		// Extended features off: no period load at all
		wr(pbs_pkg::ADDR_CTRL, M_RLD);
		v = p ^ 16'h5A5A;
		wr(pbs_pkg::ADDR_PERIOD, {16'h0000, v});
		wr(pbs_pkg::ADDR_TRIG, trig_word(3'h0, 1'b1));
		ticks(3);
		chk({16'h0000, period_limit}, {16'h0000, p});
		$display("test ext off done");
		results();
	end

endmodule
`default_nettype wire
